// ==== amc_pkg.sv ====
`default_nettype none

// ============================================================
// shared constants for the converter control register bank
// ============================================================
package amc_pkg;

  // serial port framing
  localparam int          ADDR_W       = 13;  // register address width
  localparam int          DATA_W       = 8;   // register data width
  localparam logic [4:0]  INSTR_BITS   = 5'h10; // read flag, 2 length, 13 addr
  localparam logic [4:0]  FRAME_BITS   = 5'h18; // instruction plus one byte
  localparam int          RW_BIT       = 15;  // instruction read flag

  // register indices in the bank
  localparam int NUM_REGS  = 12;
  localparam int IDX_MASK  = 0;
  localparam int IDX_DIGC  = 1;
  localparam int IDX_CALC  = 2;
  localparam int IDX_THA   = 3;
  localparam int IDX_THB   = 4;
  localparam int IDX_DIVC  = 5;
  localparam int IDX_TRIM  = 6;
  localparam int IDX_RSV   = 7;
  localparam int IDX_GAIN  = 8;
  localparam int IDX_PINCL = 9;
  localparam int IDX_PINCH = 10;
  localparam int IDX_SRCLR = 11;

  // byte offsets on the serial port
  localparam logic [ADDR_W-1:0] STATUS_OFS = 13'h0100;
  localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
    13'h0101, 13'h0105, 13'h010A, 13'h010D, 13'h010E, 13'h0120,
    13'h0121, 13'h012A, 13'h0130, 13'h0131, 13'h0132, 13'h003A};

  // writable bits; all others ignore writes and read zero
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
    8'hBD, 8'h1F, 8'h10, 8'hFF, 8'hFF, 8'h1B,
    8'h03, 8'hFF, 8'h33, 8'hFF, 8'h03, 8'h40};

  // reset values; trim entry is replaced by the grade value
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'hBC, 8'h00, 8'h10, 8'h3D, 8'h14, 8'h11,
    8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};

  // speed grades and their trim reset values
  localparam logic [1:0] GRADE_LOW  = 2'h0;
  localparam logic [1:0] GRADE_MID  = 2'h1;
  localparam logic [1:0] GRADE_HIGH = 2'h2;
  localparam logic [7:0] TRIM_RST_FAST = 8'h00;
  localparam logic [7:0] TRIM_RST_SLOW = 8'h03;

  // field positions
  localparam int MASK_PLL_BIT   = 7;
  localparam int MASK_HOLD_BIT  = 3;
  localparam int MASK_SETUP_BIT = 2;
  localparam int MASK_CLK_BIT   = 0;
  localparam int CAL_EN_BIT     = 4;
  localparam int DIV_EN_BIT     = 4;
  localparam int DIV_TERM_BIT   = 3;
  localparam int SREF_CLR_BIT   = 6;
  localparam int GAIN2_LSB      = 4;
  localparam int GAIN8_LSB      = 0;

  // divided clock ratio and phase increment width
  localparam logic [1:0] DIV_RATIO_M1 = 2'h3;  // divide by 4
  localparam int         PINC_W       = 10;    // 1024 steps per turn

  // serial slave states
  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_INSTR = 2'b01,
    SPI_DATA  = 2'b10,
    SPI_DONE  = 2'b11
  } amc_spi_state_type;

endpackage : amc_pkg

`default_nettype wire

// ==== amc_divided_clock_output.sv ====
`default_nettype none

// ============================================================
// divided clock output: sample clock over four
// ============================================================
module amc_divided_clock_output import amc_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic enable,
  // output pin level
  output logic      div_out
);

  logic [1:0] div_cnt;  // free running phase of the divider

  // free running counter so phase is stable across enable toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
    end else if (div_cnt == DIV_RATIO_M1) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // registered output, parked low while disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_out <= 1'b0;
    end else begin
      div_out <= enable & div_cnt[1];
    end
  end

endmodule : amc_divided_clock_output

`default_nettype wire

// ==== amc_spi.sv ====
`default_nettype none

// ============================================================
// serial control port slave, sampled on the core clock
// ============================================================
module amc_spi import amc_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // serial pins
  input  wire logic              spi_sclk,
  input  wire logic              spi_csb_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe_n,
  // register side
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  output logic                   reg_wr,
  input  wire logic [DATA_W-1:0] reg_rdata
);

  amc_spi_state_type state;      // frame phase
  logic              sclk_q;     // last sclk level
  logic [4:0]        bit_cnt;    // bits taken this frame
  logic [15:0]       shift_in;   // incoming shift register
  logic [7:0]        shift_out;  // read data shifter
  logic              is_read;    // frame is a read
  logic              rise;
  logic              fall;

  assign rise = spi_sclk & ~sclk_q;
  assign fall = ~spi_sclk & sclk_q;

  // edge history of the serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
    end
  end

  // frame sequencing; chip select high aborts any frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SPI_IDLE;
      bit_cnt   <= 5'h00;
      shift_in  <= 16'h0000;
      is_read   <= 1'b0;
      reg_addr  <= '0;
      reg_wdata <= '0;
      reg_wr    <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      if (spi_csb_n) begin
        state   <= SPI_IDLE;
        bit_cnt <= 5'h00;
      end else if (rise) begin
        shift_in <= {shift_in[14:0], sdio_in};
        bit_cnt  <= bit_cnt + 5'h01;
        unique case (state)
          SPI_IDLE, SPI_INSTR: begin
            state <= SPI_INSTR;
            if (bit_cnt == INSTR_BITS - 5'h01) begin
              // instruction complete, address known
              is_read  <= shift_in[RW_BIT-1];
              reg_addr <= {shift_in[ADDR_W-2:0], sdio_in};
              state    <= SPI_DATA;
            end
          end
          SPI_DATA: begin
            if (bit_cnt == FRAME_BITS - 5'h01) begin
              state <= SPI_DONE;
              if (!is_read) begin
                reg_wdata <= {shift_in[6:0], sdio_in};
                reg_wr    <= 1'b1;
              end
            end
          end
          SPI_DONE: begin
            // extra bits beyond one byte are ignored
            state <= SPI_DONE;
          end
        endcase
      end
    end
  end

  // read data: load after instruction, shift on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else if (spi_csb_n || state == SPI_DONE) begin
      sdio_oe_n <= 1'b1;
    end else if (state == SPI_DATA && is_read && bit_cnt == INSTR_BITS
                 && sdio_oe_n) begin
      shift_out <= {reg_rdata[6:0], 1'b0};
      sdio_out  <= reg_rdata[7];
      sdio_oe_n <= 1'b0;
    end else if (fall && !sdio_oe_n) begin
      sdio_out  <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

endmodule : amc_spi

`default_nettype wire

// ==== amc_registers.sv ====
`default_nettype none

// ============================================================
// converter control register bank
// ============================================================
module amc_registers import amc_pkg::*; #(
  parameter logic [1:0] RATE_GRADE = GRADE_MID  // speed grade strap
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // serial control port
  input  wire logic              spi_sclk,
  input  wire logic              spi_csb_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe_n,
  // error events from the converter
  input  wire logic              pll_unlocked,
  input  wire logic              sysref_hold_event,
  input  wire logic              sysref_setup_event,
  input  wire logic              clock_error_event,
  // interrupt request
  output logic                   irq_request,
  // calibration controls
  output logic                   cal_threshold_enable,
  output logic [DATA_W-1:0]      cal_threshold_a,
  output logic [DATA_W-1:0]      cal_threshold_b,
  output logic [DATA_W-1:0]      digital_control_reserved,
  output logic [DATA_W-1:0]      reserved_hold_default,
  // divided clock output
  output logic                   divided_clock_output,
  output logic                   divided_clock_no_term,
  output logic [1:0]             divided_clock_swing,
  // trim and downconverter zero
  output logic [1:0]             rate_trim,
  output logic [1:0]             ddc0_gain_dec2,
  output logic [1:0]             ddc0_gain_dec8,
  output logic [PINC_W-1:0]      ddc0_phase_inc,
  output logic [PINC_W-1:0]      ddc0_nco_phase
);

  // ============================================================
  // reset release
  // ============================================================
  logic rst_q1;  // first stage, read only by second
  logic rst_n;   // released reset used everywhere

  // async assert, release after two edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ============================================================
  // serial port
  // ============================================================
  logic [ADDR_W-1:0] reg_addr;   // addressed register
  logic [DATA_W-1:0] reg_wdata;  // byte to write
  logic              reg_wr;     // one-cycle write strobe
  logic [DATA_W-1:0] reg_rdata;  // read mux output

  amc_spi u_spi (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .spi_sclk  (spi_sclk),
    .spi_csb_n (spi_csb_n),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rdata (reg_rdata)
  );

  // ============================================================
  // register storage
  // ============================================================
  localparam logic [7:0] TRIM_RST =
    (RATE_GRADE == GRADE_LOW) ? TRIM_RST_SLOW : TRIM_RST_FAST;

  logic [DATA_W-1:0] regs [NUM_REGS];  // stored register values

  // one writable register per entry; masked bits stay zero
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    localparam logic [7:0] RST_VAL =
      (i == IDX_TRIM) ? TRIM_RST : REG_RST[i];
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        regs[i] <= RST_VAL;
      end else if (reg_wr && reg_addr == REG_OFS[i]) begin
        regs[i] <= reg_wdata & REG_WMASK[i];
      end
    end
  end

  // ============================================================
  // error flags
  // ============================================================
  logic sref_clr_q;     // last value of the clear control bit
  logic sref_clear;     // set-then-clear completed
  logic hold_err;       // sticky hold error
  logic setup_err;      // sticky setup error
  logic clk_err;        // sticky clock error
  logic [7:0] status;   // status byte

  // clear fires on the falling edge of the control bit
  assign sref_clear = sref_clr_q & ~regs[IDX_SRCLR][SREF_CLR_BIT];

  // history of the clear control bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sref_clr_q <= 1'b0;
    end else begin
      sref_clr_q <= regs[IDX_SRCLR][SREF_CLR_BIT];
    end
  end

  // a pulse too short for software to poll still latches here
  // hold error: a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_err <= 1'b0;
    end else if (sysref_hold_event) begin
      hold_err <= 1'b1;
    end else if (sref_clear) begin
      hold_err <= 1'b0;
    end
  end

  // setup error: a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_err <= 1'b0;
    end else if (sysref_setup_event) begin
      setup_err <= 1'b1;
    end else if (sref_clear) begin
      setup_err <= 1'b0;
    end
  end

  // clock error: output data untrustworthy, only reset recovers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_err <= 1'b0;
    end else if (clock_error_event) begin
      clk_err <= 1'b1;
    end
  end

  // status byte; pll bit is live, not sticky
  always_comb begin
    status                 = 8'h00;
    status[MASK_PLL_BIT]   = pll_unlocked;
    status[MASK_HOLD_BIT]  = hold_err;
    status[MASK_SETUP_BIT] = setup_err;
    status[MASK_CLK_BIT]   = clk_err;
  end

  // request raised by any unmasked status bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= |(status & ~regs[IDX_MASK]);
    end
  end

  // ============================================================
  // read path
  // ============================================================
  // unmapped addresses read zero
  // status decoded here so the pll bit reads live, not latched
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == STATUS_OFS) begin
      reg_rdata = status;
    end
    for (int k = 0; k < NUM_REGS; k++) begin
      if (reg_addr == REG_OFS[k]) begin
        reg_rdata = regs[k];
      end
    end
  end

  // ============================================================
  // field outputs
  // ============================================================
  assign cal_threshold_enable     = regs[IDX_CALC][CAL_EN_BIT];
  assign cal_threshold_a          = regs[IDX_THA];
  assign cal_threshold_b          = regs[IDX_THB];
  assign digital_control_reserved = regs[IDX_DIGC];
  assign reserved_hold_default    = regs[IDX_RSV];
  assign divided_clock_no_term    = regs[IDX_DIVC][DIV_TERM_BIT];
  assign divided_clock_swing      = regs[IDX_DIVC][1:0];
  assign rate_trim                = regs[IDX_TRIM][1:0];
  assign ddc0_gain_dec2 = regs[IDX_GAIN][GAIN2_LSB +: 2];
  assign ddc0_gain_dec8 = regs[IDX_GAIN][GAIN8_LSB +: 2];
  assign ddc0_phase_inc = {regs[IDX_PINCH][1:0], regs[IDX_PINCL]};

  // divided clock generator, quarter of the sample clock
  amc_divided_clock_output u_divided_clock_output (
    .clk     (core_clk),
    .rst_n   (rst_n),
    .enable  (regs[IDX_DIVC][DIV_EN_BIT]),
    .div_out (divided_clock_output)
  );

  // nco phase: wraps at 1024, so frequency is inc*fs/1024
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ddc0_nco_phase <= '0;
    end else begin
      ddc0_nco_phase <= ddc0_nco_phase + ddc0_phase_inc;
    end
  end

  // ============================================================
  // checks
  // ============================================================
  // checks sleep while the released reset is low
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  mask_reset_a: assert property ($rose(rst_n) |->
    regs[IDX_MASK] == 8'hBC) else $error("mask reset value wrong");
  pll_unmasked_a: assert property (
    pll_unlocked && !regs[IDX_MASK][MASK_PLL_BIT] |=> irq_request)
    else $error("unmasked pll unlock gave no request");
  pll_masked_a: assert property (
    regs[IDX_MASK] == 8'hBC && !hold_err && !setup_err && !clk_err
    ##0 $stable(regs[IDX_MASK]) |=> !irq_request)
    else $error("masked events raised a request");
  hold_clear_a: assert property (
    sref_clear && !sysref_hold_event |=> !hold_err)
    else $error("hold error not cleared");
  hold_set_a: assert property (
    sysref_hold_event |=> hold_err)
    else $error("hold event lost");
  setup_clear_a: assert property (
    sref_clear && !sysref_setup_event |=> !setup_err)
    else $error("setup error not cleared");
  setup_set_a: assert property (
    sysref_setup_event ##1 !sref_clear |-> setup_err [*2])
    else $error("setup event lost");
  clk_irq_a: assert property (
    clk_err && !regs[IDX_MASK][MASK_CLK_BIT] |=> irq_request)
    else $error("unmasked clock error gave no request");
  clk_sticky_a: assert property (clk_err |=> clk_err)
    else $error("clock error cleared without reset");
  unused_zero_a: assert property (
    (regs[IDX_DIVC] & ~REG_WMASK[IDX_DIVC]) == 8'h00)
    else $error("unused divider bits set");
  divided_clock_output_off_a: assert property (
    !regs[IDX_DIVC][DIV_EN_BIT] [*2] |-> !divided_clock_output)
    else $error("divided clock runs while disabled");
  divided_clock_output_rate_a: assert property (
    regs[IDX_DIVC][DIV_EN_BIT] [*6] ##0 $rose(divided_clock_output)
    |=> divided_clock_output ##1 !divided_clock_output
        ##1 !divided_clock_output)
    else $error("divided clock not quarter rate");
  nco_step_a: assert property ($stable(ddc0_phase_inc) |=>
    ddc0_nco_phase ==
    PINC_W'($past(ddc0_nco_phase) + $past(ddc0_phase_inc)))
    else $error("nco step wrong");
  trim_reset_a: assert property ($rose(rst_n) |->
    regs[IDX_TRIM] == TRIM_RST) else $error("trim reset wrong");
  write_back_a: assert property (
    reg_wr && reg_addr == REG_OFS[IDX_THA] |=> cal_threshold_a ==
    $past(reg_wdata)) else $error("threshold write lost");

  irq_seen_c:   cover property ($rose(irq_request));
  sref_clr_c:   cover property (hold_err ##1 sref_clear ##1 !hold_err);
  divided_clock_output_on_c:  cover property ($rose(divided_clock_output));
  read_c:       cover property (!sdio_oe_n);
  clk_err_c:    cover property ($rose(clk_err));

endmodule : amc_registers

`default_nettype wire

// ==== adc_misc_control_registers_tb_top.sv ====
`default_nettype none

// ============================================================
// self-checking bench for the converter control register bank
// ============================================================
module adc_misc_control_registers_tb_top import amc_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  // offsets, reset values and writable bits, in bank order
  localparam logic [12:0] T_ADDR [11] = '{13'h0101, 13'h0105, 13'h010A,
    13'h010D, 13'h010E, 13'h0120, 13'h0121, 13'h012A, 13'h0130,
    13'h0131, 13'h0132};
  localparam logic [7:0] T_RST [11] = '{8'hBC, 8'h00, 8'h10, 8'h3D,
    8'h14, 8'h11, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] T_WMSK [11] = '{8'hBD, 8'h1F, 8'h10, 8'hFF,
    8'hFF, 8'h1B, 8'h03, 8'hFF, 8'h33, 8'hFF, 8'h03};

  // stimulus
  logic       core_clk, resetn, spi_sclk, spi_csb_n, sdio_in;
  logic       pll_unlocked, sysref_hold_event, sysref_setup_event;
  logic       clock_error_event;
  // observed outputs
  logic       sdio_out, sdio_oe_n, irq_request, cal_threshold_enable;
  logic [7:0] cal_threshold_a, cal_threshold_b;
  logic [7:0] digital_control_reserved, reserved_hold_default;
  logic       divided_clock_output, divided_clock_no_term;
  logic [1:0] divided_clock_swing, rate_trim;
  logic [1:0] ddc0_gain_dec2, ddc0_gain_dec8;
  logic [9:0] ddc0_phase_inc, ddc0_nco_phase;
  // bookkeeping
  int         num_errors = 0;
  int         compares   = 0;
  logic [7:0] lastw [11];

  // lowest grade, so the distinctive trim default shows
  amc_registers #(.RATE_GRADE(GRADE_LOW)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .pll_unlocked(pll_unlocked),
    .sysref_hold_event(sysref_hold_event),
    .sysref_setup_event(sysref_setup_event),
    .clock_error_event(clock_error_event), .irq_request(irq_request),
    .cal_threshold_enable(cal_threshold_enable),
    .cal_threshold_a(cal_threshold_a), .cal_threshold_b(cal_threshold_b),
    .digital_control_reserved(digital_control_reserved),
    .reserved_hold_default(reserved_hold_default),
    .divided_clock_output(divided_clock_output),
    .divided_clock_no_term(divided_clock_no_term),
    .divided_clock_swing(divided_clock_swing), .rate_trim(rate_trim),
    .ddc0_gain_dec2(ddc0_gain_dec2), .ddc0_gain_dec8(ddc0_gain_dec8),
    .ddc0_phase_inc(ddc0_phase_inc), .ddc0_nco_phase(ddc0_nco_phase));

  // ============================================================
  // clock and helpers
  // ============================================================
  // 100 mhz core clock
  always #5 core_clk = ~core_clk;

  // step past n rising edges, then a fixed skew
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // single comparison point, four-state exact
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // phase accumulator wraps modulo one full turn
  function automatic logic [9:0] nco_next(input logic [9:0] ph,
                                          input logic [9:0] inc);
    return 10'(ph + inc);
  endfunction : nco_next

  // one 24-bit frame; sclk levels held well over two core cycles
  task automatic spi_frame(input logic [15:0] instr, input logic [7:0] wd,
                           output logic [7:0] rd);
    logic [23:0] bits;
    bits = {instr, wd};
    rd = 8'h00;
    spi_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      sdio_in  = bits[i];
      tick(3);
      spi_sclk = 1'b1;
      tick(4);
      // read bits sampled before the falling edge that shifts them
      if (i >= 1 && i <= 8) begin
        rd[i-1] = sdio_out;
        check("sdio_oe_n", sdio_oe_n, !instr[15]);
      end
    end
    spi_sclk = 1'b0;
    tick(3);
    spi_csb_n = 1'b1;
    tick(4);
    check("sdio_oe_n idle", sdio_oe_n, 1'b1);
  endtask : spi_frame

  // register write, no address auto-increment
  task automatic reg_wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    spi_frame({3'b000, a}, d, dummy);
  endtask : reg_wr

  // register read
  task automatic reg_rd(input logic [12:0] a, output logic [7:0] d);
    spi_frame({3'b100, a}, 8'h00, d);
  endtask : reg_rd

  // hold reset 3 cycles, then wait for the synchroniser
  task automatic do_reset();
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(4);
  endtask : do_reset

  // counts highs and level changes of the divided clock over 8 cycles
  task automatic div_count(output int hi, output int chg);
    logic prev;
    hi = 0;
    chg = 0;
    prev = divided_clock_output;
    repeat (8) begin
      tick(1);
      if (divided_clock_output === 1'b1) hi++;
      if (divided_clock_output !== prev) chg++;
      prev = divided_clock_output;
    end
  endtask : div_count

  // verdict, the only exit
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ============================================================
  // watchdog: about three and a half times the expected run
  // ============================================================
  initial begin
    #500000;
    num_errors++;
    final_report();
  end

  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    logic [7:0] rd, wd;
    logic [9:0] ph;
    int         hi, chg;
    core_clk = 1'b0;
    resetn = 1'b0;
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    sdio_in = 1'b0;
    pll_unlocked = 1'b0;
    sysref_hold_event = 1'b0;
    sysref_setup_event = 1'b0;
    clock_error_event = 1'b0;
    void'($urandom(32253));
    do_reset();

    // reset values over the serial port and at the ports
    for (int k = 0; k < 11; k++) begin
      reg_rd(T_ADDR[k], rd);
      check("reset value", rd, T_RST[k]);
    end
    check("cal enable", cal_threshold_enable, 1'b1);
    check("trim port", rate_trim, 2'h3);
    check("swing port", divided_clock_swing, 2'h1);
    reg_rd(13'h0100, rd);
    check("status idle", rd, 8'h00);
    $display("test reset_defaults done");

    // random round, then an all-ones corner round
    for (int n = 0; n < 2; n++) begin
      for (int k = 0; k < 11; k++) begin
        wd = (n == 0) ? 8'($urandom) : 8'hFF;
        // software duties: fixed bits, reserved value, slow-grade trim
        if (k == 0) wd = wd | 8'h30;
        if (k == 1) wd = wd & 8'hE0;
        if (k == 6) wd = wd | 8'h03;
        if (k == 7) wd = 8'h05;
        reg_wr(T_ADDR[k], wd);
        lastw[k] = wd;
        reg_rd(T_ADDR[k], rd);
        check("readback", rd, wd & T_WMSK[k]);
      end
      check("cal enable", cal_threshold_enable, lastw[2][4]);
      check("threshold a", cal_threshold_a, lastw[3]);
      check("threshold b", cal_threshold_b, lastw[4]);
      check("no term", divided_clock_no_term, lastw[5][3]);
      check("swing", divided_clock_swing, lastw[5][1:0]);
      check("trim", rate_trim, lastw[6][1:0]);
      check("dig ctrl", digital_control_reserved, 8'h00);
      check("reserved", reserved_hold_default, 8'h05);
      check("gain dec2", ddc0_gain_dec2, lastw[8][5:4]);
      check("gain dec8", ddc0_gain_dec8, lastw[8][1:0]);
      check("phase inc", ddc0_phase_inc, {lastw[10][1:0], lastw[9]});
    end
    $display("test readback done");

    // unmapped place and read-only status ignore writes
    reg_wr(13'h0102, 8'hA5);
    reg_rd(13'h0102, rd);
    check("unmapped", rd, 8'h00);
    reg_wr(13'h0100, 8'hFF);
    reg_rd(13'h0100, rd);
    check("status ro", rd, 8'h00);
    $display("test unmapped done");

    // accumulator advances by the programmed increment each cycle
    ph = ddc0_nco_phase;
    tick(1);
    ph = nco_next(ph, {lastw[10][1:0], lastw[9]});
    check("nco step", ddc0_nco_phase, ph);
    $display("test nco done");

    // quarter-rate clock when enabled, low when disabled
    reg_wr(13'h0120, 8'h10);
    div_count(hi, chg);
    check("div high", 16'(hi), 16'd4);
    check("div toggles", 16'(chg), 16'd4);
    reg_wr(13'h0120, 8'h00);
    div_count(hi, chg);
    check("div off", 16'(hi), 16'd0);
    $display("test divided_clock done");

    // pll unlock: live status, gated by mask bit 7
    reg_wr(13'h0101, 8'h30);
    pll_unlocked = 1'b1;
    tick(3);
    check("irq pll", irq_request, 1'b1);
    reg_rd(13'h0100, rd);
    check("status pll", rd, 8'h80);
    reg_wr(13'h0101, 8'hB0);
    tick(2);
    check("irq pll masked", irq_request, 1'b0);
    pll_unlocked = 1'b0;
    reg_wr(13'h0101, 8'h30);

    // hold then setup error: sticky until set-then-clear of 0x03A bit 6
    for (int e = 0; e < 2; e++) begin
      sysref_hold_event = (e == 0);
      sysref_setup_event = (e == 1);
      tick(1);
      sysref_hold_event = 1'b0;
      sysref_setup_event = 1'b0;
      tick(2);
      check("irq sysref", irq_request, 1'b1);
      reg_wr(13'h003A, 8'h40);
      reg_rd(13'h0100, rd);
      check("sysref sticky", rd, (e == 0) ? 8'h08 : 8'h04);
      reg_wr(13'h003A, 8'h00);
      reg_rd(13'h0100, rd);
      check("sysref cleared", rd, 8'h00);
      check("irq cleared", irq_request, 1'b0);
    end
    $display("test sysref_errors done");

    // clock error survives the clear sequence, only reset removes it
    clock_error_event = 1'b1;
    tick(1);
    clock_error_event = 1'b0;
    tick(2);
    check("irq clock err", irq_request, 1'b1);
    reg_wr(13'h003A, 8'h40);
    reg_wr(13'h003A, 8'h00);
    reg_rd(13'h0100, rd);
    check("clock err sticky", rd, 8'h01);
    do_reset();
    reg_rd(13'h0100, rd);
    check("clock err reset", rd, 8'h00);
    check("irq after reset", irq_request, 1'b0);
    $display("test clock_error done");

    final_report();
  end

endmodule : adc_misc_control_registers_tb_top

`default_nettype wire
